// ===== src/acs_pkg.sv
`default_nettype none
package acs_pkg;
  localparam int          CLK_HZ          = 125_000_000;
  localparam logic [4:0]  ADDR_CTRL_A     = 5'h00;
  localparam logic [4:0]  ADDR_CTRL_B     = 5'h04;
  localparam logic [4:0]  ADDR_IRQ        = 5'h08;
  localparam logic [4:0]  ADDR_RES_HI     = 5'h0C;
  localparam logic [4:0]  ADDR_RES_LO     = 5'h10;
  localparam int          A_START_BIT     = 0;
  localparam int          A_BUSY_BIT      = 1;
  localparam int          A_PWR_BIT       = 2;
  localparam int          A_CHAN_LSB      = 4;
  localparam int          A_TEMP_BIT      = 8;
  localparam int          A_FMT_BIT       = 9;
  localparam int          B_DIV_LSB       = 0;
  localparam int          B_PIN_BIT       = 3;
  localparam int          B_EXT_BIT       = 4;
  localparam int          B_PTAT_BIT      = 5;
  localparam int          B_GAIN_BIT      = 6;
  localparam int          I_GLOBAL_BIT    = 0;
  localparam int          I_ENABLE_BIT    = 1;
  localparam int          I_REQ_BIT       = 2;
  localparam int          RES_BITS        = 12;
  localparam logic [11:0] RES_FULL_SCALE  = 12'hFFF;
  localparam logic [11:0] SAR_FIRST_BIT   = 12'h800;
  localparam logic [5:0]  SAMPLE_CYCLES   = 6'h04;
  localparam logic [5:0]  RESOLVE_CYCLES  = 6'h0C;
  localparam logic [5:0]  EXT_TOTAL       = 6'h10;
  localparam logic [5:0]  TEMP_TOTAL      = 6'h38;
  localparam logic [5:0]  TEMP_SAMPLE     = TEMP_TOTAL - RESOLVE_CYCLES;
  localparam logic [6:0]  DIV_CNT_RESET   = 7'h00;
  localparam logic [31:0] WORD_RESET      = 32'h0000_0000;

  typedef struct packed {
    logic       result_format_sel;
    logic       temp_sensor_enable;
    logic [3:0] input_channel_sel;
    logic       conv_power_enable;
    logic       start;
  } acs_ctrl_a_type;

  typedef struct packed {
    logic       ref_gain_sel;
    logic       ref_source_ptat_sel;
    logic       ref_external_sel;
    logic       ref_pin_sel;
    logic [2:0] conv_clock_div_sel;
  } acs_ctrl_b_type;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_SAMPLE, SEQ_RESOLVE} acs_state_type;
endpackage : acs_pkg
`default_nettype wire

// ===== src/acs_clk_div.sv
`default_nettype none
module acs_clk_div
  import acs_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [2:0] sel,
  input  wire logic       restart,
  output logic            tick
);
  logic [6:0] cnt_q;
  logic [6:0] last;

  assign last = 7'((8'h01 << sel) - 8'h01);

  // The count restarts with each launch so the first sample period is whole.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= DIV_CNT_RESET;
      tick  <= 1'b0;
    end else if (restart) begin
      cnt_q <= DIV_CNT_RESET;
      tick  <= 1'b0;
    end else if (cnt_q >= last) begin
      cnt_q <= DIV_CNT_RESET;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 7'h01;
      tick  <= 1'b0;
    end
  end
endmodule // acs_clk_div
`default_nettype wire

// ===== src/acs_sar.sv
`default_nettype none
module acs_sar
  import acs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        clear,
  input  wire logic        step,
  input  wire logic        comp_high,
  output logic [11:0]      code
);
  logic [11:0] mask_q;

  // One trial bit is kept or dropped per resolve cycle, most significant first.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      code   <= SAR_FIRST_BIT;
      mask_q <= SAR_FIRST_BIT;
    end else if (clear) begin
      code   <= SAR_FIRST_BIT;
      mask_q <= SAR_FIRST_BIT;
    end else if (step && mask_q != 12'h000) begin
      code   <= (comp_high ? code : (code & ~mask_q)) | (mask_q >> 1);
      mask_q <= mask_q >> 1;
    end
  end
endmodule // acs_sar
`default_nettype wire

// ===== src/acs_top.sv
`default_nettype none
module acs_top
  import acs_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        NRST,
  input  wire logic [4:0]  WB_ADR_I,
  input  wire logic [31:0] WB_DAT_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic        WB_WE_I,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  output logic [31:0]      WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        COMP_HIGH,
  output logic [11:0]      DAC_CODE,
  output logic             SAMPLE_EN,
  output logic             ANALOG_PWR_EN,
  output logic [2:0]       EXT_CHAN_SEL,
  output logic             EXT_CHAN_EN,
  output logic             TEMP_SENSE_EN,
  output logic             REF_PIN_SEL,
  output logic             REF_EXTERNAL_SEL,
  output logic             REF_PTAT_SEL,
  output logic             REF_GAIN_SEL,
  output logic             CONV_BUSY,
  output logic             IRQ_OUT
);

  acs_ctrl_a_type ctrl_a_q;
  acs_ctrl_b_type ctrl_b_q;
  acs_state_type  state_q;
  logic           start_prev_q;
  logic           busy_q;
  logic           global_irq_enable_q;
  logic           conv_irq_enable_q;
  logic           conv_irq_request_q;
  logic [11:0]    result_q;
  logic [5:0]     tick_cnt_q;
  logic [5:0]     sample_len_q;
  logic           temp_conv_q;
  logic           ack_q;
  logic [31:0]    rdata_q;

  logic           req;
  logic           wr_commit;
  logic           launch;
  logic           sensor_route;
  logic           ad_tick;
  logic           sar_clear;
  logic           sar_step;
  logic           conv_done;
  logic [11:0]    sar_code;
  logic [7:0]     res_hi;
  logic [7:0]     res_lo;

  // Bus request and commit: writes land on the edge that shows ack.
  assign req       = WB_CYC_I && WB_STB_I;
  assign wr_commit = req && WB_WE_I && ack_q;

  // Start going low after being high launches; power off blocks it.
  assign launch = start_prev_q && !ctrl_a_q.start && ctrl_a_q.conv_power_enable;

  // The sensor is only routed when enabled and the top code bit is set.
  // Codes 0xxx with the sensor enabled still route the external channel.
  assign sensor_route = ctrl_a_q.temp_sensor_enable && ctrl_a_q.input_channel_sel[3];

  assign sar_clear = ctrl_a_q.start || launch;
  assign sar_step  = ad_tick && state_q == SEQ_RESOLVE;
  assign conv_done = sar_step && tick_cnt_q == RESOLVE_CYCLES - 6'h01;

  // Left aligned when the format bit is low, right aligned when high.
  always_comb begin
    if (ctrl_a_q.result_format_sel) begin
      res_hi = {4'h0, result_q[11:8]};
      res_lo = result_q[7:0];
    end else begin
      res_hi = result_q[11:4];
      res_lo = {result_q[3:0], 4'h0};
    end
  end

  acs_clk_div u_div (
    .clk     (CLK),
    .nrst    (NRST),
    .sel     (ctrl_b_q.conv_clock_div_sel),
    .restart (sar_clear),
    .tick    (ad_tick)
  );

  acs_sar u_sar (
    .clk       (CLK),
    .nrst      (NRST),
    .clear     (sar_clear),
    .step      (sar_step),
    .comp_high (COMP_HIGH),
    .code      (sar_code)
  );

  // Wishbone answer one cycle after the request; ack drops the cycle after.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req && !ack_q;
    end
  end

  // Read data is captured on the request edge and held until the next request.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rdata_q <= WORD_RESET;
    end else if (req && !ack_q) begin
      rdata_q <= WORD_RESET;
      case (WB_ADR_I)
        ADDR_CTRL_A: begin
          rdata_q[A_FMT_BIT]                  <= ctrl_a_q.result_format_sel;
          rdata_q[A_TEMP_BIT]                 <= ctrl_a_q.temp_sensor_enable;
          rdata_q[A_CHAN_LSB +: 4]            <= ctrl_a_q.input_channel_sel;
          rdata_q[A_PWR_BIT]                  <= ctrl_a_q.conv_power_enable;
          rdata_q[A_BUSY_BIT]                 <= busy_q;
          rdata_q[A_START_BIT]                <= ctrl_a_q.start;
        end
        ADDR_CTRL_B: begin
          rdata_q[B_DIV_LSB +: 3]             <= ctrl_b_q.conv_clock_div_sel;
          rdata_q[B_PIN_BIT]                  <= ctrl_b_q.ref_pin_sel;
          rdata_q[B_EXT_BIT]                  <= ctrl_b_q.ref_external_sel;
          rdata_q[B_PTAT_BIT]                 <= ctrl_b_q.ref_source_ptat_sel;
          rdata_q[B_GAIN_BIT]                 <= ctrl_b_q.ref_gain_sel;
        end
        ADDR_IRQ: begin
          rdata_q[I_GLOBAL_BIT]               <= global_irq_enable_q;
          rdata_q[I_ENABLE_BIT]               <= conv_irq_enable_q;
          rdata_q[I_REQ_BIT]                  <= conv_irq_request_q;
        end
        ADDR_RES_HI: rdata_q[7:0]             <= res_hi;
        ADDR_RES_LO: rdata_q[7:0]             <= res_lo;
        default:     rdata_q                  <= WORD_RESET;
      endcase
    end
  end

  // Control register A; all fields sit in byte lanes 0 and 1.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ctrl_a_q <= '0;
    end else if (wr_commit && WB_ADR_I == ADDR_CTRL_A) begin
      if (WB_SEL_I[0]) begin
        ctrl_a_q.start             <= WB_DAT_I[A_START_BIT];
        ctrl_a_q.conv_power_enable <= WB_DAT_I[A_PWR_BIT];
        ctrl_a_q.input_channel_sel <= WB_DAT_I[A_CHAN_LSB +: 4];
      end
      if (WB_SEL_I[1]) begin
        ctrl_a_q.temp_sensor_enable <= WB_DAT_I[A_TEMP_BIT];
        ctrl_a_q.result_format_sel  <= WB_DAT_I[A_FMT_BIT];
      end
    end
  end

  // Control register B holds the divider and the reference routing.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ctrl_b_q <= '0;
    end else if (wr_commit && WB_ADR_I == ADDR_CTRL_B && WB_SEL_I[0]) begin
      ctrl_b_q.conv_clock_div_sel  <= WB_DAT_I[B_DIV_LSB +: 3];
      ctrl_b_q.ref_pin_sel         <= WB_DAT_I[B_PIN_BIT];
      ctrl_b_q.ref_external_sel    <= WB_DAT_I[B_EXT_BIT];
      ctrl_b_q.ref_source_ptat_sel <= WB_DAT_I[B_PTAT_BIT];
      ctrl_b_q.ref_gain_sel        <= WB_DAT_I[B_GAIN_BIT];
    end
  end

  // Start is remembered for one cycle so that its falling edge can be seen.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      start_prev_q <= 1'b0;
    end else begin
      start_prev_q <= ctrl_a_q.start;
    end
  end

  // Sequencer. Sample length is fixed at launch so a mid-conversion
  // change of input selection cannot stretch or cut the running one.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state_q      <= SEQ_IDLE;
      tick_cnt_q   <= 6'h00;
      sample_len_q <= SAMPLE_CYCLES;
      temp_conv_q  <= 1'b0;
    end else if (ctrl_a_q.start || !ctrl_a_q.conv_power_enable) begin
      state_q    <= SEQ_IDLE;
      tick_cnt_q <= 6'h00;
    end else if (launch) begin
      state_q      <= SEQ_SAMPLE;
      tick_cnt_q   <= 6'h00;
      temp_conv_q  <= sensor_route;
      sample_len_q <= sensor_route ? TEMP_SAMPLE : SAMPLE_CYCLES;
    end else if (ad_tick) begin
      case (state_q)
        SEQ_SAMPLE: begin
          if (tick_cnt_q == sample_len_q - 6'h01) begin
            state_q    <= SEQ_RESOLVE;
            tick_cnt_q <= 6'h00;
          end else begin
            tick_cnt_q <= tick_cnt_q + 6'h01;
          end
        end
        SEQ_RESOLVE: begin
          if (conv_done) begin
            state_q    <= SEQ_IDLE;
            tick_cnt_q <= 6'h00;
          end else begin
            tick_cnt_q <= tick_cnt_q + 6'h01;
          end
        end
        SEQ_IDLE: tick_cnt_q <= 6'h00;
        default: begin
          state_q    <= SEQ_IDLE;
          tick_cnt_q <= 6'h00;
        end
      endcase
    end
  end

  // Busy rises at launch and falls with the last resolve cycle.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      busy_q <= 1'b0;
    end else if (ctrl_a_q.start || !ctrl_a_q.conv_power_enable) begin
      busy_q <= 1'b0;
    end else if (launch) begin
      busy_q <= 1'b1;
    end else if (conv_done) begin
      busy_q <= 1'b0;
    end
  end

  // Last decision is folded in here since the SAR register lags by one edge.
  function automatic logic [11:0] comp_keep(input logic [11:0] c, input logic k);
    comp_keep = k ? c : (c & 12'hFFE);
  endfunction

  // The result is only updated at the end, so an aborted run keeps the old value.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      result_q <= 12'h000;
    end else if (conv_done) begin
      result_q <= (comp_keep(sar_code, COMP_HIGH)) & RES_FULL_SCALE;
    end
  end

  // The enables only gate the pin; the request flag is kept regardless.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      global_irq_enable_q <= 1'b0;
      conv_irq_enable_q   <= 1'b0;
    end else if (wr_commit && WB_ADR_I == ADDR_IRQ && WB_SEL_I[0]) begin
      global_irq_enable_q <= WB_DAT_I[I_GLOBAL_BIT];
      conv_irq_enable_q   <= WB_DAT_I[I_ENABLE_BIT];
    end
  end

  // End of conversion sets the request; writing zero clears it, set wins.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      conv_irq_request_q <= 1'b0;
    end else if (conv_done) begin
      conv_irq_request_q <= 1'b1;
    end else if (wr_commit && WB_ADR_I == ADDR_IRQ && WB_SEL_I[0] && !WB_DAT_I[I_REQ_BIT]) begin
      conv_irq_request_q <= 1'b0;
    end
  end

  // Registered pin outputs. Routing follows the power bit directly, so a
  // powered-down converter never has an input connected.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ANALOG_PWR_EN    <= 1'b0;
      EXT_CHAN_SEL     <= 3'h0;
      EXT_CHAN_EN      <= 1'b0;
      TEMP_SENSE_EN    <= 1'b0;
      SAMPLE_EN        <= 1'b0;
      REF_PIN_SEL      <= 1'b0;
      REF_EXTERNAL_SEL <= 1'b0;
      REF_PTAT_SEL     <= 1'b0;
      REF_GAIN_SEL     <= 1'b0;
    end else begin
      ANALOG_PWR_EN    <= ctrl_a_q.conv_power_enable;
      EXT_CHAN_SEL     <= ctrl_a_q.input_channel_sel[2:0];
      EXT_CHAN_EN      <= ctrl_a_q.conv_power_enable && !sensor_route;
      TEMP_SENSE_EN    <= ctrl_a_q.conv_power_enable && sensor_route;
      SAMPLE_EN        <= state_q == SEQ_SAMPLE && ctrl_a_q.conv_power_enable;
      REF_PIN_SEL      <= ctrl_b_q.ref_pin_sel;
      REF_EXTERNAL_SEL <= ctrl_b_q.ref_external_sel;
      REF_PTAT_SEL     <= ctrl_b_q.ref_source_ptat_sel;
      REF_GAIN_SEL     <= ctrl_b_q.ref_gain_sel;
    end
  end

  // Status pins lag the register view by one cycle, so a poll sees busy first.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      CONV_BUSY <= 1'b0;
      IRQ_OUT   <= 1'b0;
    end else begin
      CONV_BUSY <= busy_q;
      IRQ_OUT   <= conv_irq_request_q && conv_irq_enable_q && global_irq_enable_q;
    end
  end

  // The trial code comes straight from the SAR register. A registered copy would
  // lag one edge, and with an undivided A/D clock the comparator would then judge
  // the previous trial.
  assign DAC_CODE = sar_code;

  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = rdata_q;

  // Held for visibility of which sample length ran; read by nothing else.
  logic unused_temp;
  assign unused_temp = temp_conv_q;

endmodule // acs_top
`default_nettype wire

// ===== tb/acs_props.sv
`default_nettype none
module acs_props
  import acs_pkg::*;
(
  input wire logic        CLK,
  input wire logic        NRST,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  input wire logic        SAMPLE_EN,
  input wire logic        ANALOG_PWR_EN,
  input wire logic        EXT_CHAN_EN,
  input wire logic        TEMP_SENSE_EN,
  input wire logic        CONV_BUSY,
  input wire logic        IRQ_OUT
);
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!NRST);
  sequence s_req;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  sequence s_samp_go;
    $rose(SAMPLE_EN);
  endsequence
  property p_ack_next;
    s_req |=> WB_ACK_O;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("request not answered in one cycle");
  property p_ack_once;
    WB_ACK_O |=> !WB_ACK_O;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
  property p_dat_upper;
    WB_ACK_O |-> WB_DAT_O[31:10] == 22'h0;
  endproperty
  a_dat_upper: assert property (p_dat_upper) else $error("upper read bits not zero");
  property p_route_excl;
    !(EXT_CHAN_EN && TEMP_SENSE_EN);
  endproperty
  a_route_excl: assert property (p_route_excl) else $error("both inputs routed");
  property p_pwr_off;
    !ANALOG_PWR_EN |-> !EXT_CHAN_EN && !TEMP_SENSE_EN;
  endproperty
  a_pwr_off: assert property (p_pwr_off) else $error("input routed while unpowered");
  property p_ext_sample;
    s_samp_go ##0 EXT_CHAN_EN |-> SAMPLE_EN [*4];
  endproperty
  a_ext_sample: assert property (p_ext_sample) else $error("external sampling too short");
  property p_temp_sample;
    s_samp_go ##0 TEMP_SENSE_EN |-> SAMPLE_EN [*8];
  endproperty
  a_temp_sample: assert property (p_temp_sample) else $error("sensor sampling too short");
  property p_busy_cover;
    s_samp_go |-> ##[0:2] CONV_BUSY;
  endproperty
  a_busy_cover: assert property (p_busy_cover) else $error("busy low while sampling");
  // Allow one cycle of skew between the two registered copies.
  property p_irq_end;
    $rose(IRQ_OUT) |-> !CONV_BUSY && $past(CONV_BUSY, 2);
  endproperty
  a_irq_end: assert property (p_irq_end) else $error("request not raised at end of conversion");
endmodule // acs_props
bind acs_top acs_props props_u (.CLK(CLK), .NRST(NRST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .SAMPLE_EN(SAMPLE_EN), .ANALOG_PWR_EN(ANALOG_PWR_EN),
  .EXT_CHAN_EN(EXT_CHAN_EN), .TEMP_SENSE_EN(TEMP_SENSE_EN), .CONV_BUSY(CONV_BUSY), .IRQ_OUT(IRQ_OUT));
`default_nettype wire

// ===== tb/acs_analog_model.sv
`default_nettype none
module acs_analog_model (
  input  wire logic        clk,
  input  wire logic        pwr_en,
  input  wire logic [11:0] trial,
  input  wire logic [11:0] level,
  output logic             comp_high
);
  timeunit 1ns;
  timeprecision 1ps;
  logic toggle_q = 1'h0;
  always @(posedge clk) toggle_q <= ~toggle_q;
  // An unpowered core gives a changing pattern so a stale answer never looks valid.
  assign comp_high = pwr_en ? (level >= trial) : toggle_q;
endmodule // acs_analog_model
`default_nettype wire

// ===== tb/testbench.sv
`default_nettype none
module testbench
  import acs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [2:0]  dv;
    logic [3:0]  ch;
    logic        ts;
    logic        fm;
    logic [11:0] lv;
    logic        ex;
    logic [5:0]  tot;
  } acs_row_type;
  localparam acs_row_type ROWS [8] = '{
    '{3'h0, 4'h0, 1'h0, 1'h0, 12'h6B9, 1'h1, EXT_TOTAL},
    '{3'h1, 4'h7, 1'h0, 1'h1, 12'hA5C, 1'h1, EXT_TOTAL},
    '{3'h2, 4'hF, 1'h0, 1'h0, 12'h000, 1'h1, EXT_TOTAL},
    '{3'h3, 4'h8, 1'h1, 1'h1, 12'h3C7, 1'h0, TEMP_TOTAL},
    '{3'h4, 4'h3, 1'h1, 1'h0, 12'h123, 1'h1, EXT_TOTAL},
    '{3'h5, 4'hC, 1'h1, 1'h1, 12'h800, 1'h0, TEMP_TOTAL},
    '{3'h6, 4'h5, 1'h0, 1'h0, 12'hFFF, 1'h1, EXT_TOTAL},
    '{3'h7, 4'hE, 1'h0, 1'h1, 12'h001, 1'h1, EXT_TOTAL}};
  logic        clk, nrst, cyc, stb, we, ack, comp, samp, pwr, chen, tsen;
  logic        rpin, rext, rptat, rgain, busy, irq;
  logic [4:0]  adr;
  logic [31:0] wdat, rdat, rd, a;
  logic [3:0]  sel;
  logic [11:0] lvl, dac;
  logic [2:0]  chsel;
  int          n, e, miscompares, check_count;
  acs_top dut_u (.CLK(clk), .NRST(nrst), .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_SEL_I(sel),
    .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .COMP_HIGH(comp), .DAC_CODE(dac), .SAMPLE_EN(samp), .ANALOG_PWR_EN(pwr),
    .EXT_CHAN_SEL(chsel), .EXT_CHAN_EN(chen), .TEMP_SENSE_EN(tsen), .REF_PIN_SEL(rpin),
    .REF_EXTERNAL_SEL(rext), .REF_PTAT_SEL(rptat), .REF_GAIN_SEL(rgain), .CONV_BUSY(busy), .IRQ_OUT(irq));
  acs_analog_model model_u (.clk(clk), .pwr_en(pwr), .trial(dac), .level(lvl), .comp_high(comp));
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (g !== x) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic lim(input int c, input int m);
    if (c >= m) begin
      miscompares++;
      test_done();
    end
  endtask
  task automatic wb(input logic w, input logic [4:0] ad, input logic [31:0] d, input logic [3:0] s);
    int k;
    k = 0;
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= ad;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'h1 && k < 64);
    lim(k, 64);
    rd = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    @(posedge clk);
  endtask
  task automatic wait_idle;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((busy !== 1'h0 || n < 3) && n < 20000);
    lim(n, 20000);
  endtask
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  initial begin
    nrst = 1'h0;
    cyc = 1'h0;
    stb = 1'h0;
    we = 1'h0;
    adr = 5'h00;
    wdat = 32'h0;
    sel = 4'h0;
    lvl = 12'h000;
    miscompares = 0;
    check_count = 0;
    repeat (16) @(posedge clk);
    nrst <= 1'h1;
    @(posedge clk);
    wb(1'h0, ADDR_CTRL_A, 32'h0, 4'hF);
    chk("ctrl_a reset", 32'h0, rd);
    chk("busy reset", 32'h0, busy);
    for (int i = 0; i < 8; i++) begin
      lvl <= ROWS[i].lv;
      wb(1'h1, ADDR_CTRL_B, {25'h0, i[3:0], ROWS[i].dv}, 4'hF);
      a = {22'h0, ROWS[i].fm, ROWS[i].ts, ROWS[i].ch, 4'h4};
      wb(1'h1, ADDR_CTRL_A, a, 4'hF);
      repeat (8) @(posedge clk);
      wb(1'h1, ADDR_CTRL_A, a | 32'h1, 4'hF);
      wb(1'h1, ADDR_CTRL_A, a, 4'hF);
      wait_idle();
      e = int'(ROWS[i].tot) << ROWS[i].dv;
      chk("duration", 32'h1, n >= e - 2 && n <= e + 4);
      chk("external route", ROWS[i].ex, chen);
      chk("sensor route", !ROWS[i].ex, tsen);
      chk("channel code", ROWS[i].ch[2:0], chsel);
      chk("ref bits", i[3:0], {rgain, rptat, rext, rpin});
      wb(1'h0, ADDR_CTRL_A, 32'h0, 4'hF);
      chk("busy bit clear", a, rd);
      wb(1'h0, ADDR_RES_HI, 32'h0, 4'hF);
      chk("result hi", ROWS[i].fm ? {28'h0, ROWS[i].lv[11:8]} : {24'h0, ROWS[i].lv[11:4]}, rd);
      wb(1'h0, ADDR_RES_LO, 32'h0, 4'hF);
      chk("result lo", ROWS[i].fm ? {24'h0, ROWS[i].lv[7:0]} : {24'h0, ROWS[i].lv[3:0], 4'h0}, rd);
    end
    // Clearing the stale request in the same write that enables avoids a false interrupt.
    wb(1'h1, ADDR_IRQ, 32'h3, 4'hF);
    wb(1'h1, ADDR_CTRL_A, 32'h5, 4'hF);
    repeat (40) @(posedge clk);
    chk("held in reset", 32'h0, busy);
    wb(1'h1, ADDR_CTRL_A, 32'h4, 4'hF);
    repeat (4) @(posedge clk);
    wb(1'h0, ADDR_CTRL_A, 32'h0, 4'hF);
    chk("busy while converting", 32'h6, rd);
    chk("irq idle", 32'h0, irq);
    n = 0;
    while (irq !== 1'h1 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    lim(n, 20000);
    chk("irq raised", 32'h1, irq);
    chk("busy at irq", 32'h0, busy);
    wb(1'h0, ADDR_IRQ, 32'h0, 4'hF);
    chk("irq reg", 32'h7, rd);
    wb(1'h1, ADDR_IRQ, 32'h3, 4'hF);
    wb(1'h0, ADDR_IRQ, 32'h0, 4'hF);
    chk("irq cleared", 32'h3, rd);
    chk("irq out low", 32'h0, irq);
    wb(1'h1, ADDR_CTRL_A, 32'h10, 4'hF);
    wb(1'h1, ADDR_CTRL_A, 32'h11, 4'hF);
    wb(1'h1, ADDR_CTRL_A, 32'h10, 4'hF);
    repeat (8) @(posedge clk);
    chk("power off", 32'h0, pwr);
    chk("mux off", 32'h0, chen);
    chk("no launch", 32'h0, busy);
    wb(1'h1, ADDR_CTRL_A, 32'h214, 4'h2);
    wb(1'h0, ADDR_CTRL_A, 32'h0, 4'hF);
    chk("lane write", 32'h210, rd);
    wb(1'h1, 5'h14, 32'hFFFF_FFFF, 4'hF);
    wb(1'h0, 5'h14, 32'h0, 4'hF);
    chk("unmapped", 32'h0, rd);
    // A reset in mid-conversion must drop busy and clear every field of control register A.
    wb(1'h1, ADDR_CTRL_A, 32'h5, 4'hF);
    wb(1'h1, ADDR_CTRL_A, 32'h4, 4'hF);
    repeat (8) @(posedge clk);
    chk("busy before reset", 32'h1, busy);
    nrst <= 1'h0;
    repeat (2) @(posedge clk);
    chk("busy in reset", 32'h0, busy);
    chk("power in reset", 32'h0, pwr);
    nrst <= 1'h1;
    @(posedge clk);
    wb(1'h0, ADDR_CTRL_A, 32'h0, 4'hF);
    chk("ctrl_a after reset", 32'h0, rd);
    test_done();
  end
endmodule // testbench
`default_nettype wire
